/* rtl/nvsc_host.sv */
// host controller driving an 8k x 8 nonvolatile sram over its pins
// assumes pins are synchronous to clk_i; the bench resolves data_bus and store_busy_n wires
//
// What this block does
// - hold store_busy_n low at least 250 ns for a hardware store
// - store_busy_n is open drain; only pull low, never drive high
// - each initiation read lasts at least 55 ns; here chip_sel_n is low for ACC_CYCLES - 1 cycles, which is 50 ns
// - keep wr_en_n high while chip_sel_n low in the sequence
// - one chip_sel_n low pulse per sequence address
// - store sequence: 0000 1555 0aaa 1fff 10f0 0f0f
// - write: chip_sel_n and wr_en_n low, address stable, data at rising edge
// - keep out_en_n high during writes
// - recall sequence ends with 0f0e instead of 0f0f
`timescale 1ns/1ns
`default_nettype none
module nvsc_host #(
	parameter int STORE_CYCLES = nvsc_pkg::STORE_CYC,
	parameter int RECALL_CYCLES = nvsc_pkg::RECALL_CYC,
	parameter int ACC_CYCLES = nvsc_pkg::SEQ_READ_CYC
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic req_valid_i,
	input wire nvsc_pkg::nvsc_req_t req_i,
	input wire logic hw_store_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [7:0] rsp_data_o,
	output logic busy_o,
	output logic chip_sel_n_o,
	output logic wr_en_n_o,
	output logic out_en_n_o,
	output logic [12:0] addr_bus_o,
	input wire logic [7:0] data_bus_i,
	output logic [7:0] data_bus_o,
	output logic data_bus_oe_o,
	input wire logic store_busy_n_i,
	output logic store_busy_n_o,
	output logic store_busy_n_oe_o
);
	typedef enum logic [3:0] {
		S_POWERUP = 4'h0,
		S_IDLE = 4'h1,
		S_ACC = 4'h3,
		S_GAP = 4'h2,
		S_NVWAIT = 4'h6,
		S_HSB = 4'h7,
		S_HSBWAIT = 4'h5,
		S_RECOVER = 4'h4
	} nvsc_state_t;

	nvsc_state_t state;
	nvsc_pkg::nvsc_req_t cur;
	logic [2:0] step;
	logic [17:0] acc_cnt;
	logic wait_load;
	logic [17:0] wait_count;
	logic wait_done;

	function automatic logic [12:0] nvsc_seq_addr(input logic [2:0] s, input logic [1:0] op);
		case (s)
			3'h0: nvsc_seq_addr = nvsc_pkg::SEQ_A0;
			3'h1: nvsc_seq_addr = nvsc_pkg::SEQ_A1;
			3'h2: nvsc_seq_addr = nvsc_pkg::SEQ_A2;
			3'h3: nvsc_seq_addr = nvsc_pkg::SEQ_A3;
			3'h4: nvsc_seq_addr = nvsc_pkg::SEQ_A4;
			default: nvsc_seq_addr = (op == nvsc_pkg::CMD_SW_STORE) ? nvsc_pkg::SEQ_STORE :
				nvsc_pkg::SEQ_RECALL;
		endcase
	endfunction : nvsc_seq_addr

	function automatic logic nvsc_is_seq(input logic [1:0] op);
		nvsc_is_seq = (op == nvsc_pkg::CMD_SW_STORE) || (op == nvsc_pkg::CMD_SW_RECALL);
	endfunction : nvsc_is_seq

	nvsc_wait #(
		.W(18)
	) u_wait (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.load_i(wait_load),
		.count_i(wait_count),
		.done_o(wait_done)
	);

	// wait loads: nonvolatile durations and hardware pulse
	always_comb begin
		wait_load = 1'b0;
		wait_count = '0;
		if (state == S_POWERUP && srst_i == 1'b0 && step == 3'h0) begin
			wait_load = 1'b1;
			wait_count = 18'(RECALL_CYCLES);
		end else if (state == S_GAP && nvsc_is_seq(cur.op) && step == 3'(nvsc_pkg::SEQ_STEPS)) begin
			wait_load = 1'b1;
			wait_count = (cur.op == nvsc_pkg::CMD_SW_STORE) ? 18'(STORE_CYCLES) :
				18'(RECALL_CYCLES);
		end else if (state == S_IDLE && hw_store_i) begin
			wait_load = 1'b1;
			wait_count = 18'(nvsc_pkg::HSB_PULSE_CYC);
		end else if (state == S_HSBWAIT && step == 3'h1) begin
			// device may serve on for the onset delay before it inhibits
			wait_load = 1'b1;
			wait_count = 18'(nvsc_pkg::ONSET_CYC);
		end else if (state == S_HSBWAIT && step == 3'h3 && store_busy_n_i) begin
			wait_load = 1'b1;
			wait_count = 18'(nvsc_pkg::RELEASE_CYC + 1);
		end
	end

	// main sequencer
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state <= S_POWERUP;
			step <= 3'h0;
			acc_cnt <= '0;
			cur <= '0;
		end else begin
			case (state)
				S_POWERUP: begin
					step <= 3'h1;
					if (step != 3'h0 && wait_done) begin
						state <= S_IDLE;
						step <= 3'h0;
					end
				end
				S_IDLE: begin
					step <= 3'h0;
					if (hw_store_i) begin
						state <= S_HSB;
					end else if (!store_busy_n_i) begin
						// another agent holds the line: device inhibited
						state <= S_HSBWAIT;
						step <= 3'h3;
					end else if (req_valid_i) begin
						cur <= req_i;
						acc_cnt <= 18'(ACC_CYCLES);
						state <= S_ACC;
					end
				end
				S_ACC: begin
					if (acc_cnt > 18'h1) begin
						acc_cnt <= acc_cnt - 18'h1;
					end else begin
						state <= S_GAP;
						if (nvsc_is_seq(cur.op)) begin
							step <= step + 3'h1;
						end
					end
				end
				S_GAP: begin
					if (nvsc_is_seq(cur.op) && step != 3'(nvsc_pkg::SEQ_STEPS)) begin
						acc_cnt <= 18'(ACC_CYCLES);
						state <= S_ACC;
					end else if (nvsc_is_seq(cur.op)) begin
						state <= S_NVWAIT;
					end else begin
						state <= S_IDLE;
					end
				end
				S_NVWAIT: begin
					if (wait_done) begin
						state <= S_HSBWAIT;
						step <= 3'h3;
					end
				end
				S_HSB: begin
					if (wait_done) begin
						state <= S_HSBWAIT;
						step <= 3'h1;
					end
				end
				S_HSBWAIT: begin
					// step 1 loads the onset wait, 2 waits it out, 3 waits for the line
					if (step == 3'h1) begin
						step <= 3'h2;
					end else if (step == 3'h2) begin
						if (wait_done) begin
							step <= 3'h3;
						end
					end else if (step == 3'h3 && store_busy_n_i) begin
						state <= S_RECOVER;
					end
				end
				S_RECOVER: begin
					if (wait_done) begin
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// pin drive, registered
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			chip_sel_n_o <= 1'b1;
			wr_en_n_o <= 1'b1;
			out_en_n_o <= 1'b1;
			addr_bus_o <= '0;
			data_bus_o <= '0;
			data_bus_oe_o <= 1'b0;
		end else begin
			chip_sel_n_o <= 1'b1;
			wr_en_n_o <= 1'b1;
			out_en_n_o <= 1'b1;
			data_bus_oe_o <= 1'b0;
			if (state == S_ACC && acc_cnt > 18'h1) begin
				chip_sel_n_o <= 1'b0;
				if (cur.op == nvsc_pkg::CMD_WRITE) begin
					wr_en_n_o <= 1'b0;
					data_bus_oe_o <= 1'b1;
					data_bus_o <= cur.wdata;
				end else begin
					out_en_n_o <= 1'b0;
				end
			end
			if (state == S_IDLE && req_valid_i && !hw_store_i && store_busy_n_i) begin
				addr_bus_o <= nvsc_is_seq(req_i.op) ? nvsc_pkg::SEQ_A0 : req_i.addr;
			end else if (state == S_GAP && nvsc_is_seq(cur.op) && step != 3'(nvsc_pkg::SEQ_STEPS)) begin
				addr_bus_o <= nvsc_seq_addr(step, cur.op);
			end
		end
	end

	// store_busy_n pull-down, never driven high
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			store_busy_n_oe_o <= 1'b0;
			store_busy_n_o <= 1'b0;
		end else begin
			store_busy_n_oe_o <= (state == S_HSB) && !wait_done;
			store_busy_n_o <= 1'b0;
		end
	end

	// answers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rsp_valid_o <= 1'b0;
			rsp_data_o <= '0;
			req_ready_o <= 1'b0;
			busy_o <= 1'b1;
		end else begin
			rsp_valid_o <= 1'b0;
			if (state == S_ACC && acc_cnt == 18'h1 && cur.op == nvsc_pkg::CMD_READ) begin
				rsp_valid_o <= 1'b1;
				rsp_data_o <= data_bus_i;
			end else if (state == S_RECOVER && wait_done) begin
				rsp_valid_o <= 1'b1;
			end else if (state == S_ACC && acc_cnt == 18'h1 && cur.op == nvsc_pkg::CMD_WRITE) begin
				rsp_valid_o <= 1'b1;
			end
			req_ready_o <= (state == S_IDLE) && !req_valid_i && !hw_store_i && store_busy_n_i;
			busy_o <= (state != S_IDLE);
		end
	end
endmodule : nvsc_host
`default_nettype wire

/* rtl/nvsc_pkg.sv */
// package for the nonvolatile sram host controller: timing, sequence addresses, carriers
// assumes a 20 MHz clock (50 ns period)
package nvsc_pkg;
	localparam int CLK_NS = 50;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	// timing figures in their own units
	localparam int RECALL_DURATION_US = 20;
	localparam int STORE_DURATION_MS = 10;
	localparam int INHIBIT_ONSET_DELAY_US = 1;
	localparam int INHIBIT_RELEASE_DELAY_NS = 300;
	localparam int EXTERNAL_STORE_PULSE_NS = 250;
	localparam int SEQ_READ_NS = 55;
	localparam int SEQUENCE_SELECT_PULSE_NS = 45;
	// derived cycle counts, least times rounded up, longest rounded down
	localparam int RECALL_CYC = (RECALL_DURATION_US * 1000) / CLK_NS;
	localparam int STORE_CYC = (STORE_DURATION_MS * 1000000) / CLK_NS;
	localparam int ONSET_CYC = (INHIBIT_ONSET_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int RELEASE_CYC = INHIBIT_RELEASE_DELAY_NS / CLK_NS;
	localparam int HSB_PULSE_CYC = (EXTERNAL_STORE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SEQ_READ_CYC = (SEQ_READ_NS + CLK_NS - 1) / CLK_NS;
	localparam int SEL_PULSE_CYC = (SEQUENCE_SELECT_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SEQ_STEPS = 6;
	localparam logic [12:0] SEQ_A0 = 13'h0000;
	localparam logic [12:0] SEQ_A1 = 13'h1555;
	localparam logic [12:0] SEQ_A2 = 13'h0aaa;
	localparam logic [12:0] SEQ_A3 = 13'h1fff;
	localparam logic [12:0] SEQ_A4 = 13'h10f0;
	localparam logic [12:0] SEQ_STORE = 13'h0f0f;
	localparam logic [12:0] SEQ_RECALL = 13'h0f0e;
	localparam logic [1:0] CMD_READ = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_SW_STORE = 2'h2;
	localparam logic [1:0] CMD_SW_RECALL = 2'h3;
	typedef struct packed {
		logic [1:0] op;
		logic [12:0] addr;
		logic [7:0] wdata;
	} nvsc_req_t;
	typedef struct packed {
		logic chip_sel_n;
		logic wr_en_n;
		logic out_en_n;
		logic [12:0] addr_bus;
	} nvsc_pins_t;
endpackage : nvsc_pkg

/* rtl/nvsc_wait.sv */
// down counter that measures a wait in clock cycles
// load starts it; done is high while idle
`timescale 1ns/1ns
`default_nettype none
module nvsc_wait #(
	parameter int W = 18
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic load_i,
	input wire logic [W-1:0] count_i,
	output logic done_o
);
	logic [W-1:0] cnt;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt <= '0;
		end else if (load_i) begin
			cnt <= count_i;
		end else if (cnt != '0) begin
			cnt <= cnt - 1'b1;
		end
	end
	assign done_o = (cnt == '0) && !load_i;
endmodule : nvsc_wait
`default_nettype wire

/* verification/nvsc_dev.sv */
// behavioural model of the nonvolatile sram facing the host
// clocked by the bench clock; srst_i stands for power-up
`timescale 1ns/1ns
`default_nettype none
module nvsc_dev #(
	parameter int SC = 40,
	parameter int RC = 16
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic chip_sel_n_i,
	input wire logic wr_en_n_i,
	input wire logic out_en_n_i,
	input wire logic [12:0] addr_bus_i,
	input wire logic [7:0] data_i,
	input wire logic store_busy_n_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	output logic pull_o,
	output int n_store_o
);
	logic [7:0] mem [8192];
	logic [7:0] nv [8192];
	logic [12:0] seq [5] = '{nvsc_pkg::SEQ_A0, nvsc_pkg::SEQ_A1, nvsc_pkg::SEQ_A2, nvsc_pkg::SEQ_A3, nvsc_pkg::SEQ_A4};
	logic [12:0] addr_q;
	logic cs_q, wr_seen, written, st, hreq;
	int t, step, lowc, pend;
	assign data_o = mem[addr_bus_i];
	assign data_oe_o = !chip_sel_n_i && !out_en_n_i && wr_en_n_i && store_busy_n_i && t == 0;
	assign pull_o = st && t > 0;
	task automatic start(input logic s);
		st = s;
		t = s ? SC : RC;
	endtask : start
	always @(posedge clk_i) begin
		if (srst_i) begin
			start(1'b0);
			{step, lowc, pend, hreq, written, wr_seen, n_store_o} = '0;
		end else if (t > 0) begin
			t--;
			for (int i = 0; i < 8192 && t == 0; i++) begin
				if (st) begin
					nv[i] = 8'hff;
					nv[i] = mem[i];
				end else
					mem[i] = nv[i];
			end
			if (t == 0 && st)
				n_store_o++;
		end else begin
			if (!chip_sel_n_i && !wr_en_n_i) begin
				mem[addr_bus_i] = data_i;
				written = 1;
				wr_seen = 1;
			end
			if (!cs_q && chip_sel_n_i) begin
				if (wr_seen)
					step = 0;
				else if (step == 5 && addr_q == nvsc_pkg::SEQ_STORE) begin
					start(1'b1);
					written = 0;
				end else if (step == 5 && addr_q == nvsc_pkg::SEQ_RECALL)
					start(1'b0);
				else if (step < 5 && addr_q == seq[step])
					step++;
				else
					step = (addr_q == 13'h0000) ? 1 : 0;
				if (t > 0)
					step = 0;
				wr_seen = 0;
			end
			lowc = (!store_busy_n_i && !pull_o) ? lowc + 1 : 0;
			hreq = hreq || lowc == nvsc_pkg::HSB_PULSE_CYC;
			pend = (lowc == 1) ? nvsc_pkg::ONSET_CYC : (pend > 0 ? pend - 1 : 0);
			if (pend == 1 && hreq && written) begin
				start(1'b1);
				written = 0;
			end
			hreq = hreq && pend != 1;
		end
		if (!chip_sel_n_i)
			addr_q = addr_bus_i;
		cs_q = chip_sel_n_i || srst_i;
	end
endmodule : nvsc_dev
`default_nettype wire

/* verification/nvsc_host_sva.sv */
// assertions on the pins of the nonvolatile sram host controller
// bound to nvsc_host from tb_top; one clock domain
`timescale 1ns/1ns
`default_nettype none
module nvsc_host_sva (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic rsp_valid_o,
	input wire logic busy_o,
	input wire logic req_ready_o,
	input wire logic chip_sel_n_o,
	input wire logic wr_en_n_o,
	input wire logic out_en_n_o,
	input wire logic [12:0] addr_bus_o,
	input wire logic data_bus_oe_o,
	input wire logic store_busy_n_i,
	input wire logic store_busy_n_o,
	input wire logic store_busy_n_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence s_pull;
		store_busy_n_oe_o [*5];
	endsequence
	sequence s_strobe;
		$stable(addr_bus_o) ##1 $stable(addr_bus_o);
	endsequence
	a_pull_only: assert property (store_busy_n_oe_o |-> !store_busy_n_o)
		else $error("store line driven high");
	a_pulse_len: assert property ($rose(store_busy_n_oe_o) |-> s_pull)
		else $error("store pulse too short");
	a_addr_hold: assert property ($fell(chip_sel_n_o) |-> s_strobe)
		else $error("address moved under strobe");
	a_no_access: assert property (!store_busy_n_i |-> chip_sel_n_o)
		else $error("access while store line low");
	a_pull_busy: assert property (store_busy_n_oe_o |-> busy_o && !req_ready_o)
		else $error("idle while pulling store line");
	a_rd_qual: assert property (!out_en_n_o |-> wr_en_n_o)
		else $error("output enable low during write");
	a_wr_drive: assert property (!wr_en_n_o |-> data_bus_oe_o && !chip_sel_n_o)
		else $error("write without data or select");
	a_no_fight: assert property (!out_en_n_o |-> !data_bus_oe_o)
		else $error("bus contention");
	a_release_wait: assert property ($rose(store_busy_n_i) && busy_o |-> !rsp_valid_o [*5])
		else $error("answer before inhibit lifted");
endmodule : nvsc_host_sva
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench: host controller against the sram model
// one clock, synchronous reset held 10 cycles
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
	logic clk_i = 0, srst_i = 1, req_valid_i = 0, hw_store_i = 0;
	nvsc_pkg::nvsc_req_t req_i = '0;
	logic req_ready_o, rsp_valid_o, busy_o, chip_sel_n_o, wr_en_n_o, out_en_n_o, data_bus_oe_o;
	logic store_busy_n_o, store_busy_n_oe_o, dev_oe, pull;
	logic [7:0] rsp_data_o, data_bus_o, dev_d, rd, pat = 8'h00;
	logic [12:0] addr_bus_o;
	wire logic [7:0] data_bus = data_bus_oe_o ? data_bus_o : (dev_oe ? dev_d : pat);
	wire logic store_busy_n = !(store_busy_n_oe_o || pull);
	int n_mismatch = 0, num_checks = 0, ns;
	always #25 clk_i = !clk_i;
	always @(posedge clk_i) pat <= pat + 8'h3b;
	nvsc_host #(.STORE_CYCLES(50), .RECALL_CYCLES(20)) DUT (.clk_i(clk_i), .srst_i(srst_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .hw_store_i(hw_store_i), .req_ready_o(req_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .busy_o(busy_o), .chip_sel_n_o(chip_sel_n_o),
		.wr_en_n_o(wr_en_n_o), .out_en_n_o(out_en_n_o), .addr_bus_o(addr_bus_o), .data_bus_i(data_bus),
		.data_bus_o(data_bus_o), .data_bus_oe_o(data_bus_oe_o), .store_busy_n_i(store_busy_n),
		.store_busy_n_o(store_busy_n_o), .store_busy_n_oe_o(store_busy_n_oe_o));
	nvsc_dev DEV (.clk_i(clk_i), .srst_i(srst_i), .chip_sel_n_i(chip_sel_n_o), .wr_en_n_i(wr_en_n_o),
		.out_en_n_i(out_en_n_o), .addr_bus_i(addr_bus_o), .data_i(data_bus), .store_busy_n_i(store_busy_n),
		.data_o(dev_d), .data_oe_o(dev_oe), .pull_o(pull), .n_store_o());
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#5;
	endtask : tick
	task automatic wait_on(input logic want_rsp);
		int k;
		k = 0;
		while ((want_rsp ? rsp_valid_o : !busy_o) !== 1'b1) begin
			tick(1);
			k++;
			if (k > 3000) begin
				n_mismatch++;
				complete_run();
			end
		end
	endtask : wait_on
	task automatic do_req(input logic [1:0] op, input logic [12:0] a, input logic [7:0] d);
		wait_on(1'b0);
		req_i = '{op, a, d};
		req_valid_i = 1;
		tick(1);
		req_valid_i = 0;
		wait_on(1'b1);
		rd = rsp_data_o;
	endtask : do_req
	task automatic hw_pulse;
		wait_on(1'b0);
		hw_store_i = 1;
		tick(1);
		hw_store_i = 0;
		wait_on(1'b1);
		tick(nvsc_pkg::ONSET_CYC + 50);
	endtask : hw_pulse
	task automatic t_rw;
		logic [12:0] a [3] = '{13'h0000, 13'h1555, 13'h1fff};
		for (int i = 0; i < 3; i++)
			do_req(nvsc_pkg::CMD_WRITE, a[i], 8'ha0 + 8'(i));
		for (int i = 0; i < 3; i++) begin
			do_req(nvsc_pkg::CMD_READ, a[i], 8'h00);
			`CHK(rd, 8'ha0 + 8'(i))
		end
	endtask : t_rw
	task automatic t_store;
		ns = DEV.n_store_o;
		do_req(nvsc_pkg::CMD_WRITE, 13'h0123, 8'h5c);
		do_req(nvsc_pkg::CMD_SW_STORE, 13'h0000, 8'h00);
		`CHK(DEV.n_store_o, ns + 1)
		`CHK(DEV.nv[13'h0123], 8'h5c)
		do_req(nvsc_pkg::CMD_SW_STORE, 13'h0000, 8'h00);
		`CHK(DEV.n_store_o, ns + 2)
	endtask : t_store
	task automatic t_recall;
		do_req(nvsc_pkg::CMD_WRITE, 13'h0123, 8'h11);
		do_req(nvsc_pkg::CMD_SW_RECALL, 13'h0000, 8'h00);
		do_req(nvsc_pkg::CMD_READ, 13'h0123, 8'h00);
		`CHK(rd, 8'h5c)
	endtask : t_recall
	task automatic t_hw;
		ns = DEV.n_store_o;
		hw_pulse();
		`CHK(DEV.n_store_o, ns + 1)
		hw_pulse();
		`CHK(DEV.n_store_o, ns + 1)
		do_req(nvsc_pkg::CMD_WRITE, 13'h0042, 8'h77);
		hw_pulse();
		`CHK(DEV.n_store_o, ns + 2)
		`CHK(DEV.nv[13'h0042], 8'h77)
		do_req(nvsc_pkg::CMD_READ, 13'h0042, 8'h00);
		`CHK(rd, 8'h77)
	endtask : t_hw
	initial begin
		tick(10);
		`CHK(busy_o, 1'b1)
		srst_i = 0;
		t_rw();
		t_store();
		t_recall();
		t_hw();
		complete_run();
	end
endmodule : tb_top
bind nvsc_host nvsc_host_sva SVA (.clk_i(clk_i), .srst_i(srst_i), .rsp_valid_o(rsp_valid_o), .busy_o(busy_o),
	.req_ready_o(req_ready_o), .chip_sel_n_o(chip_sel_n_o), .wr_en_n_o(wr_en_n_o), .out_en_n_o(out_en_n_o),
	.addr_bus_o(addr_bus_o), .data_bus_oe_o(data_bus_oe_o), .store_busy_n_i(store_busy_n_i),
	.store_busy_n_o(store_busy_n_o), .store_busy_n_oe_o(store_busy_n_oe_o));
`default_nettype wire
